// ---- verilog/ppc_pkg.sv ----
// Purpose: Constants for the parallel port control register block.
// Assumes: One 16-bit control register on a plain register port.
// Notes:   Bit 14 and bit 4 are unimplemented.
`default_nettype none

package ppc_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0]  PPC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0]  PPC_ADDR_STATUS  = 4'h1;
    localparam logic [15:0] PPC_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PPC_CONTROL_MASK  = 16'hBFEF;

    // ==========================================================
    // Field positions
    localparam int PPC_BIT_PORT_EN    = 15;
    localparam int PPC_BIT_STOP_IDLE  = 13;
    localparam int PPC_BIT_MUX_HI     = 12;
    localparam int PPC_BIT_MUX_LO     = 11;
    localparam int PPC_BIT_BE_EN      = 10;
    localparam int PPC_BIT_WR_EN      = 9;
    localparam int PPC_BIT_RD_EN      = 8;
    localparam int PPC_BIT_CSF_HI     = 7;
    localparam int PPC_BIT_CSF_LO     = 6;
    localparam int PPC_BIT_ALP        = 5;
    localparam int PPC_BIT_CSP        = 3;

    // ==========================================================
    // Encodings
    localparam logic [1:0] PPC_MUX_SEPARATE = 2'h0;
    localparam logic [1:0] PPC_MUX_LOW8     = 2'h1;
    localparam logic [1:0] PPC_MUX_FULL16   = 2'h2;
    localparam logic [1:0] PPC_CSF_CHIPSEL  = 2'h2;

    typedef enum logic [2:0] {
        PPC_ST_OFF  = 3'h1,
        PPC_ST_RUN  = 3'h2,
        PPC_ST_HALT = 3'h4
    } ppc_state_t;

endpackage : ppc_pkg

`default_nettype wire

// ---- verilog/ppc_sync.sv ----
// Purpose: Two-flop synchroniser for a level from outside the clock domain.
// Assumes: Input is a slow level.
// Notes:   First flop feeds only the second.
`default_nettype none

module ppc_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule : ppc_sync

`default_nettype wire

// ---- verilog/ppc_pin_map.sv ----
// Purpose: Maps pin functions and polarities from the control settings.
// Assumes: Strobe levels arrive active high from the bus cycle engine.
// Notes:   Purely combinational.
`default_nettype none

module ppc_pin_map
    import ppc_pkg::*;
(
    input  wire logic [1:0] chipSelFunc,
    input  wire logic       addrLatchPol,
    input  wire logic       chipSelPol,
    input  wire logic       running,
    input  wire logic       csActive,
    input  wire logic       latchActive,
    input  wire logic       addrBit14,
    output logic            chipSelPin,
    output logic            latchPin
);
    always_comb begin
        if (chipSelFunc == PPC_CSF_CHIPSEL) begin
            chipSelPin = (running & csActive) ~^ chipSelPol;
        end else begin
            // Polarity is not applied to an address line.
            chipSelPin = addrBit14;
        end
        latchPin = (running & latchActive) ~^ addrLatchPol;
    end

endmodule : ppc_pin_map

`default_nettype wire

// ---- verilog/ppc_control.sv ----
// Purpose: Control register and pin steering of the parallel master port.
// Assumes: Plain register port; read data valid in the cycle after the strobe.
// Notes:   Bus cycle timing lives in a separate engine fed by the strobe inputs.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`default_nettype none

module ppc_control
    import ppc_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [3:0]        regAddr,
    input  wire logic [15:0]       regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [15:0]       regRdData,
    input  wire logic              idleMode,
    input  wire logic              cycleReq,
    input  wire logic              cycleWrite,
    input  wire logic              cycleAddrPhase,
    input  wire logic              cycleByteHigh,
    input  wire logic [ADDR_W-1:0] cycleAddr,
    input  wire logic [DATA_W-1:0] cycleWrData,
    output logic                   busActive,
    output logic      [DATA_W-1:0] data_pins_out,
    output logic      [DATA_W-1:0] data_pins_oe,
    output logic      [ADDR_W-1:0] address_pins,
    output logic                   byte_enable_pin,
    output logic                   byte_enable_pin_oe,
    output logic                   write_strobe_pin,
    output logic                   write_strobe_pin_oe,
    output logic                   read_strobe_pin,
    output logic                   read_strobe_pin_oe,
    output logic                   chip_select_pin,
    output logic                   addr_latch_low_strobe,
    output logic                   addr_latch_high_strobe
);
    // ==========================================================
    // Control register
    logic [15:0] parallel_port_control_reg;
    logic [15:0] parallel_port_control_next;
    logic [15:0] rdData_reg;
    logic [15:0] rdData_next;
    logic        idleSync;
    ppc_state_t  state_reg;
    ppc_state_t  state_next;

    // Idle comes from another part of the device, so it is synchronised first.
    ppc_sync u_idle_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .asyncIn (idleMode),
        .syncOut (idleSync)
    );

    // Bits 14 and 4 never store, and the read path masks them again, so they read back as zero.
    function automatic logic [15:0] ppc_clean(input logic [15:0] value);
        ppc_clean = value & PPC_CONTROL_MASK;
    endfunction : ppc_clean

    // Picks one byte of the address for a multiplexed address phase.
    function automatic logic [DATA_W-1:0] ppc_addr_byte(input logic [ADDR_W-1:0] addr,
                                                        input logic              high);
        ppc_addr_byte = high ? addr[2*DATA_W-1:DATA_W] : addr[DATA_W-1:0];
    endfunction : ppc_addr_byte

    logic       port_enable_bit;
    logic       stop_in_idle_bit;
    logic [1:0] addr_data_mux_select;
    logic       byte_enable_pin_enable;
    logic       write_strobe_pin_enable;
    logic       read_strobe_pin_enable;
    logic [1:0] chip_select_function;
    logic       addr_latch_polarity;
    logic       chip_select_polarity;

    assign port_enable_bit         = parallel_port_control_reg[PPC_BIT_PORT_EN];
    assign stop_in_idle_bit        = parallel_port_control_reg[PPC_BIT_STOP_IDLE];
    assign addr_data_mux_select    = parallel_port_control_reg[PPC_BIT_MUX_HI:PPC_BIT_MUX_LO];
    assign byte_enable_pin_enable  = parallel_port_control_reg[PPC_BIT_BE_EN];
    assign write_strobe_pin_enable = parallel_port_control_reg[PPC_BIT_WR_EN];
    assign read_strobe_pin_enable  = parallel_port_control_reg[PPC_BIT_RD_EN];
    assign chip_select_function    = parallel_port_control_reg[PPC_BIT_CSF_HI:PPC_BIT_CSF_LO];
    assign addr_latch_polarity     = parallel_port_control_reg[PPC_BIT_ALP];
    assign chip_select_polarity    = parallel_port_control_reg[PPC_BIT_CSP];

    always_comb begin
        parallel_port_control_next = parallel_port_control_reg;
        rdData_next                = 16'h0000;
        if (regWrite && regAddr == PPC_ADDR_CONTROL) begin
            parallel_port_control_next = ppc_clean(regWrData);
        end
        if (regRead) begin
            unique case (regAddr)
                PPC_ADDR_CONTROL: rdData_next = ppc_clean(parallel_port_control_reg);
                PPC_ADDR_STATUS:  rdData_next = {13'h0000, state_reg};
                // Unmapped indices read as zero.
                default:          rdData_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            parallel_port_control_reg <= PPC_CONTROL_RESET;
            rdData_reg                <= 16'h0000;
        end else begin
            parallel_port_control_reg <= parallel_port_control_next;
            rdData_reg                <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;

    // ==========================================================
    // Operating state
    // Idle passes two flops first, so a halt lands two or three cycles after idle rises.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PPC_ST_OFF: begin
                if (port_enable_bit) begin
                    state_next = PPC_ST_RUN;
                end
            end
            PPC_ST_RUN: begin
                if (!port_enable_bit) begin
                    state_next = PPC_ST_OFF;
                end else if (idleSync && stop_in_idle_bit) begin
                    state_next = PPC_ST_HALT;
                end
            end
            PPC_ST_HALT: begin
                if (!port_enable_bit) begin
                    state_next = PPC_ST_OFF;
                end else if (!idleSync || !stop_in_idle_bit) begin
                    state_next = PPC_ST_RUN;
                end
            end
            default: state_next = PPC_ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= PPC_ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Pin steering
    logic                   running;
    logic                   active;
    logic [DATA_W-1:0]      dataOut_next;
    logic [ADDR_W-1:0]      addrOut_next;
    logic                   dataDrive_next;
    logic                   latchLow_next;
    logic                   latchHigh_next;
    logic [DATA_W-1:0]      dataOut_reg;
    logic [ADDR_W-1:0]      addrOut_reg;
    logic                   dataDrive_reg;
    logic                   latchLow_reg;
    logic                   latchHigh_reg;
    logic                   wr_reg;
    logic                   rd_reg;
    logic                   be_reg;
    logic                   cs_reg;
    logic                   wr_next;
    logic                   rd_next;
    logic                   be_next;
    logic                   cs_next;

    assign running   = (state_reg == PPC_ST_RUN);
    assign active    = running && cycleReq;
    // The engine sees a halt at once through busActive; the write, read and byte enable pins and the data output enable follow one cycle later.
    assign busActive = active;

    always_comb begin
        dataOut_next   = cycleWrData;
        addrOut_next   = cycleAddr;
        dataDrive_next = active && cycleWrite;
        latchLow_next  = 1'b0;
        latchHigh_next = 1'b0;
        unique case (addr_data_mux_select)
            PPC_MUX_FULL16: begin
                if (active && cycleAddrPhase) begin
                    // Two address phases share the byte-wide data pins.
                    dataOut_next   = ppc_addr_byte(cycleAddr, cycleByteHigh);
                    dataDrive_next = 1'b1;
                    latchLow_next  = !cycleByteHigh;
                    latchHigh_next = cycleByteHigh;
                end
                addrOut_next = '0;
            end
            PPC_MUX_LOW8: begin
                if (active && cycleAddrPhase) begin
                    dataOut_next   = ppc_addr_byte(cycleAddr, 1'b0);
                    dataDrive_next = 1'b1;
                    latchLow_next  = 1'b1;
                end
                addrOut_next = {cycleAddr[15:11], cycleAddr[10:8], 8'h00};
            end
            PPC_MUX_SEPARATE: begin
                addrOut_next = cycleAddr;
            end
            default: begin
                // Reserved encoding; behaves as separate pins.
                addrOut_next = cycleAddr;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut_reg   <= '0;
            addrOut_reg   <= '0;
            dataDrive_reg <= 1'b0;
            latchLow_reg  <= 1'b0;
            latchHigh_reg <= 1'b0;
        end else begin
            dataOut_reg   <= dataOut_next;
            addrOut_reg   <= addrOut_next;
            dataDrive_reg <= dataDrive_next;
            latchLow_reg  <= latchLow_next;
            latchHigh_reg <= latchHigh_next;
        end
    end

    // ==========================================================
    // Strobe pins
    // The write and read strobes mark data phases only, so an address phase never looks like an access.
    always_comb begin
        wr_next = active && cycleWrite && !cycleAddrPhase;
        rd_next = active && !cycleWrite && !cycleAddrPhase;
        be_next = active && cycleByteHigh;
        cs_next = active;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            be_reg <= 1'b0;
            cs_reg <= 1'b0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            be_reg <= be_next;
            cs_reg <= cs_next;
        end
    end

    assign data_pins_out       = dataOut_reg;
    // All data pins turn around together, so one enable serves the whole byte.
    assign data_pins_oe        = {DATA_W{dataDrive_reg}};
    assign address_pins        = addrOut_reg;
    assign byte_enable_pin     = be_reg;
    // The byte enable and strobe output enables drop at once when the port leaves the run state.
    assign byte_enable_pin_oe  = running && byte_enable_pin_enable;
    assign write_strobe_pin    = wr_reg;
    assign write_strobe_pin_oe = running && write_strobe_pin_enable;
    assign read_strobe_pin     = rd_reg;
    assign read_strobe_pin_oe  = running && read_strobe_pin_enable;

    // A control write moves the idle level of select and latch in the next cycle.
    ppc_pin_map u_pin_map (
        .chipSelFunc  (chip_select_function),
        .addrLatchPol (addr_latch_polarity),
        .chipSelPol   (chip_select_polarity),
        .running      (running),
        .csActive     (cs_reg),
        .latchActive  (latchLow_reg),
        .addrBit14    (addrOut_reg[14]),
        .chipSelPin   (chip_select_pin),
        .latchPin     (addr_latch_low_strobe)
    );

    // The high latch shares the low latch polarity.
    assign addr_latch_high_strobe = (running & latchHigh_reg) ~^ addr_latch_polarity;

endmodule : ppc_control

`default_nettype wire

// ---- verif/ppc_control_assertions.sv ----
// Purpose: Concurrent checks on the port pins of the control block.
// Assumes: A shadow of the control word follows every write to index 0.
// Notes:   Pin relations are judged one cycle after a request is taken.
`default_nettype none

module ppc_control_assertions
    import ppc_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic [3:0]        regAddr,
    input wire logic [15:0]       regWrData,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [15:0]       regRdData,
    input wire logic              idleMode,
    input wire logic              cycleReq,
    input wire logic              cycleAddrPhase,
    input wire logic              cycleByteHigh,
    input wire logic [ADDR_W-1:0] cycleAddr,
    input wire logic              busActive,
    input wire logic [DATA_W-1:0] data_pins_out,
    input wire logic [ADDR_W-1:0] address_pins,
    input wire logic              byte_enable_pin_oe,
    input wire logic              write_strobe_pin_oe,
    input wire logic              read_strobe_pin_oe,
    input wire logic              chip_select_pin,
    input wire logic              addr_latch_low_strobe
);
    // ==========================================================
    // Shadow state, kept apart so that a stuck register shows.
    logic [15:0]       shadow_reg;
    logic              rdD_reg, reqD_reg, busD_reg, phaseD_reg, highD_reg;
    logic [ADDR_W-1:0] addrD_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_reg <= 16'h0000;
            {rdD_reg, reqD_reg, busD_reg, phaseD_reg, highD_reg} <= 5'h00;
            addrD_reg <= '0;
        end else begin
            if (regWrite && regAddr == PPC_ADDR_CONTROL) begin
                shadow_reg <= regWrData & PPC_CONTROL_MASK;
            end
            rdD_reg <= regRead && regAddr == PPC_ADDR_CONTROL;
            {reqD_reg, busD_reg} <= {cycleReq, busActive};
            {phaseD_reg, highD_reg} <= {cycleAddrPhase, cycleByteHigh};
            addrD_reg <= cycleAddr;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_idle_held(stop);
        (shadow_reg[15] && shadow_reg[13] == stop && idleMode)[*4];
    endsequence
    a_readback_masked: assert property (rdD_reg |-> regRdData == $past(shadow_reg))
        else $error("control readback differs from masked write");
    a_disabled_quiet: assert property (!shadow_reg[15] && $stable(shadow_reg) |-> !busActive
        && !(byte_enable_pin_oe | write_strobe_pin_oe | read_strobe_pin_oe))
        else $error("pins active while port disabled");
    a_oe_follow_bits: assert property (busActive |->
        {byte_enable_pin_oe, write_strobe_pin_oe, read_strobe_pin_oe} == shadow_reg[10:8])
        else $error("pin enables differ from control bits");
    a_idle_halts: assert property (s_idle_held(1'b1) |-> !busActive && !write_strobe_pin_oe)
        else $error("port still active in idle with stop set");
    a_idle_runs: assert property (s_idle_held(1'b0) ##0 cycleReq |-> busActive)
        else $error("port stopped in idle with stop clear");
    a_mux_low_byte: assert property (shadow_reg[12:11] == PPC_MUX_LOW8 && busD_reg && phaseD_reg
        && $stable(shadow_reg) |-> data_pins_out == addrD_reg[7:0]
        && address_pins[10:8] == addrD_reg[10:8]) else $error("low byte address phase wrong");
    a_mux_full_addr: assert property (shadow_reg[12:11] == PPC_MUX_FULL16 && busD_reg && phaseD_reg
        && $stable(shadow_reg) |-> address_pins == '0
        && data_pins_out == (highD_reg ? addrD_reg[15:8] : addrD_reg[7:0]))
        else $error("full address phase wrong");
    a_mux_separate: assert property (shadow_reg[12:11] == PPC_MUX_SEPARATE && busD_reg
        && $stable(shadow_reg) |-> address_pins == addrD_reg) else $error("separate address wrong");
    a_cs_active: assert property (shadow_reg[7:6] == PPC_CSF_CHIPSEL && busActive && busD_reg
        && $stable(shadow_reg) |-> chip_select_pin == shadow_reg[3]) else $error("select level wrong");
    a_cs_idle: assert property (shadow_reg[7:6] == PPC_CSF_CHIPSEL && !cycleReq && !reqD_reg
        && $stable(shadow_reg) |-> chip_select_pin != shadow_reg[3]) else $error("select idle wrong");
    a_cs_addr14: assert property (!shadow_reg[7] && shadow_reg[12:11] == 2'h0 && busD_reg
        && $stable(shadow_reg) |-> chip_select_pin == addrD_reg[14]) else $error("address 14 wrong");
    a_latch_idle: assert property (!cycleReq && !reqD_reg && $stable(shadow_reg)
        |-> addr_latch_low_strobe != shadow_reg[5]) else $error("latch idle level wrong");
endmodule : ppc_control_assertions

bind ppc_control ppc_control_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) ppc_control_assertions_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .idleMode(idleMode),
    .cycleReq(cycleReq), .cycleAddrPhase(cycleAddrPhase), .cycleByteHigh(cycleByteHigh),
    .cycleAddr(cycleAddr), .busActive(busActive), .data_pins_out(data_pins_out),
    .address_pins(address_pins), .byte_enable_pin_oe(byte_enable_pin_oe),
    .write_strobe_pin_oe(write_strobe_pin_oe), .read_strobe_pin_oe(read_strobe_pin_oe),
    .chip_select_pin(chip_select_pin), .addr_latch_low_strobe(addr_latch_low_strobe));

`default_nettype wire

// ---- verif/ppc_ext_device.sv ----
// Purpose: External latch device that captures the low address byte.
// Assumes: The strobe level that counts is given by the bench.
// Notes:   An undriven bus is never captured.
`default_nettype none

module ppc_ext_device (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] busData,
    input  wire logic [7:0] busOe,
    input  wire logic       latchStrobe,
    input  wire logic       latchHigh,
    output logic      [7:0] latchedLow
);
    // ==========================================================
    // Capture
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latchedLow <= 8'h00;
        end else if (latchStrobe == latchHigh && busOe == 8'hFF) begin
            latchedLow <= busData;
        end
    end
endmodule : ppc_ext_device

`default_nettype wire

// ---- verif/tb_parallel_master_port_control.sv ----
// Purpose: Register and pin tests of the parallel port control block.
// Assumes: Strobes are driven right after a rising edge.
// Notes:   Only legal mux and select codes are written.
`default_nettype none

module tb_parallel_master_port_control import ppc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst_n, regWrite, regRead, idleMode, cycleReq, cycleWrite;
    logic        cycleAddrPhase, cycleByteHigh, busActive, beP, beOe, wrP, wrOe, rdP, rdOe;
    logic        chip_select_pin, latLo, latHi;
    logic [3:0]  regAddr;
    logic [15:0] regWrData, regRdData, cycleAddr, address_pins;
    logic [7:0]  cycleWrData, data_pins_out, data_pins_oe, latchedLow;
    int          errors, compares;

    ppc_control ppc_control_i (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .idleMode(idleMode), .cycleReq(cycleReq), .cycleWrite(cycleWrite),
        .cycleAddrPhase(cycleAddrPhase), .cycleByteHigh(cycleByteHigh), .cycleAddr(cycleAddr),
        .cycleWrData(cycleWrData), .busActive(busActive), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .address_pins(address_pins), .byte_enable_pin(beP),
        .byte_enable_pin_oe(beOe), .write_strobe_pin(wrP), .write_strobe_pin_oe(wrOe),
        .read_strobe_pin(rdP), .read_strobe_pin_oe(rdOe), .chip_select_pin(chip_select_pin),
        .addr_latch_low_strobe(latLo), .addr_latch_high_strobe(latHi));
    ppc_ext_device ppc_ext_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .busData(data_pins_out),
        .busOe(data_pins_oe), .latchStrobe(latLo), .latchHigh(1'b1), .latchedLow(latchedLow));

    // ==========================================================
    // Tasks
    always #20 sys_clk = ~sys_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(negedge sys_clk);
        check(regRdData, exp);
    endtask : rd
    task automatic cyc(input logic req, input logic ph, input logic hi, input logic [15:0] ad);
        @(posedge sys_clk);
        {cycleReq, cycleAddrPhase, cycleByteHigh, cycleAddr} <= {req, ph, hi, ad};
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : cyc
    task automatic test_done();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        test_done();
    end

    // ==========================================================
    // Sequence
    initial begin
        {rst_n, regWrite, regRead, idleMode, cycleReq, cycleWrite} = 6'h00;
        {cycleAddrPhase, cycleByteHigh, regAddr, regWrData, cycleAddr, cycleWrData} = 46'h0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(PPC_ADDR_CONTROL, PPC_CONTROL_RESET);
        rd(PPC_ADDR_STATUS, 16'h0001);
        rd(4'hF, 16'h0000);
        wr(PPC_ADDR_CONTROL, 16'hF7BF);
        rd(PPC_ADDR_CONTROL, 16'hB7AF);
        $display("test register access done");
        for (int m = 0; m < 3; m++) begin
            wr(PPC_ADDR_CONTROL, 16'h87A8 | (16'(m) << 11));
            cyc(1'b1, m != 0, m == 2, 16'h5A3C);
            check(16'(chip_select_pin), 16'h0001);
            check(16'({beP, wrP, rdP, latHi}), 16'({m == 2, 1'b0, m == 0, m == 2}));
            if (m == 0) check(address_pins, 16'h5A3C);
            if (m == 1) check(16'({address_pins[10:8], data_pins_out}), 16'h023C);
            if (m == 1) check({latchedLow, 7'h00, latLo}, 16'h3C01);
            if (m == 2) check(address_pins | 16'(data_pins_out), 16'h005A);
            rd(PPC_ADDR_STATUS, 16'h0002);
        end
        cyc(1'b0, 1'b0, 1'b0, 16'h0000);
        check(16'({chip_select_pin, latLo}), 16'h0000);
        $display("test mux modes done");
        wr(PPC_ADDR_CONTROL, 16'h8728);
        {cycleWrite, cycleWrData} <= {1'b1, 8'hC3};
        for (int i = 0; i < 2; i++) begin
            cyc(1'b1, 1'b0, 1'b0, 16'(i) << 14);
            check(16'(chip_select_pin), 16'(i));
        end
        check({data_pins_oe, data_pins_out}, 16'hFFC3);
        check(16'({wrP, rdP}), 16'h0002);
        wr(PPC_ADDR_CONTROL, 16'h8500);
        repeat (2) @(posedge sys_clk);
        check(16'({beOe, wrOe, rdOe}), 16'h0005);
        wr(PPC_ADDR_CONTROL, 16'h0700);
        repeat (2) @(posedge sys_clk);
        check(16'({beOe, wrOe, rdOe, busActive}), 16'h0000);
        rd(PPC_ADDR_STATUS, 16'h0001);
        $display("test pin enables done");
        wr(PPC_ADDR_CONTROL, 16'h8300);
        idleMode <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(PPC_ADDR_STATUS, 16'h0002);
        check(16'({busActive, wrOe}), 16'h0003);
        wr(PPC_ADDR_CONTROL, 16'hA300);
        repeat (6) @(posedge sys_clk);
        rd(PPC_ADDR_STATUS, 16'h0004);
        check(16'({busActive, wrOe}), 16'h0000);
        @(posedge sys_clk);
        idleMode <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(PPC_ADDR_STATUS, 16'h0002);
        $display("test idle done");
        test_done();
    end
endmodule : tb_parallel_master_port_control

`default_nettype wire
